//--- pkg/cir_consts.svh
`ifndef CIR_CONSTS_SVH
`define CIR_CONSTS_SVH

// command indices that reach the registers
`define CIR_CMD_GO_IDLE 6'h00
`define CIR_CMD_ALL_SEND_ID 6'h02
`define CIR_CMD_IF_COND 6'h08
`define CIR_CMD_SEND_CSD 6'h09
`define CIR_CMD_SEND_ID 6'h0A
`define CIR_CMD_PROG_CSD 6'h1B
`define CIR_CMD_OP_COND 6'h29

// operating_conditions field positions
`define CIR_OCR_BUSY_N 31
`define CIR_OCR_CAPACITY 30
`define CIR_OCR_DIFF_IF 29
`define CIR_OCR_LOW_VOLT 24
`define CIR_OCR_WIN_HI 23
`define CIR_OCR_WIN_LO 15
`define CIR_OCR_DUAL_VOLT 7
`define CIR_OCR_RESET 32'h0000_0000

// card_identification field positions
`define CIR_CID_MAKER_LO 120
`define CIR_CID_APP_LO 104
`define CIR_CID_NAME_LO 64
`define CIR_CID_REV_LO 56
`define CIR_CID_SERIAL_LO 24
`define CIR_CID_YEAR_LO 12
`define CIR_CID_MONTH_LO 8
`define CIR_CRC_LO 1
`define CIR_CRC_BODY_W 120

// card_specific_data layout
`define CIR_CSD_VER_LO 126
`define CIR_CSD_VER_1 2'h0
`define CIR_CSD_VER_2 2'h1
`define CIR_CSD_RO_MASK 110'h00FF_FFFF_FFFF_F3FF_FFFF_FFFF_9FE0
`define CIR_CSD_PROG_MASK 8'hFC
`define CIR_CSD_PROG_RESET 8'h00
`define CIR_W1_FMT_GRP 8'h80
`define CIR_W1_COPY 8'h40
`define CIR_W1_PERM_WP 8'h20
`define CIR_W1_FMT 8'h0C
`define CIR_W1_FIELDS 4

// power-up timing
`define CIR_CLK_PERIOD_NS 10
`define CIR_POWERUP_TIME_US 1000
`define CIR_POWERUP_CYCLES ((`CIR_POWERUP_TIME_US * 1000) / `CIR_CLK_PERIOD_NS)
`define CIR_PWR_CNT_W 20

`endif

//--- pkg/cir_pkg.sv
`include "cir_consts.svh"

package cir_pkg;

  // power-up progress of the card
  typedef enum logic {
    CIR_POWERING,
    CIR_READY
  } cir_phase_t;

  // whole state of the register set
  typedef struct packed {
    cir_phase_t phase;
    logic [`CIR_PWR_CNT_W-1:0] pwr_cnt;
    logic dual_volt;
    logic low_volt_ok;
    logic [`CIR_W1_FIELDS-1:0] once_done;
    logic [7:0] csd_prog;
    logic resp_valid;
    logic resp_long;
    logic resp_error;
    logic [127:0] resp_data;
  } cir_state_t;

endpackage : cir_pkg

//--- rtl/cir_crc7.sv
`timescale 1ns/1ps

module cir_crc7 #(
  parameter int unsigned DATA_W = 120
)(
  input wire logic [DATA_W-1:0] data,
  output logic [6:0] crc
);

  // serial crc7, msb first, seeded with zero, taps x^7 + x^3 + 1
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc = 7'h00;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = data[i] ^ crc[6];
      crc = {crc[5:0], 1'b0};
      if (fb) begin
        crc = crc ^ 7'h09;
      end
    end
  end

endmodule : cir_crc7

//--- rtl/cir_card_regs.sv
`timescale 1ns/1ps
`include "cir_consts.svh"


module cir_card_regs #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [15:0] APP_CODE = 16'h5858, // arbitrary value
  parameter logic [39:0] PRODUCT_NAME = 40'h43_4152_4431,
  parameter logic [3:0] REV_MAJOR = 4'h1,
  parameter logic [3:0] REV_MINOR = 4'h0,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter logic [7:0] MFG_YEAR = 8'h00,
  parameter logic [3:0] MFG_MONTH = 4'h1,
  parameter logic [8:0] VOLT_WINDOW = 9'h1FF,
  parameter bit HIGH_CAPACITY = 1'b1,
  parameter bit DUAL_VOLTAGE = 1'b1,
  parameter bit LOW_VOLT_SUPPORT = 1'b0,
  parameter bit DIFF_IF_SUPPORT = 1'b0,
  parameter logic [109:0] CSD_BODY = 110'h0,
  parameter int unsigned POWERUP_CYCLES = `CIR_POWERUP_CYCLES
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_arg,
  input wire logic [127:0] prog_data,
  output logic resp_valid,
  output logic resp_long,
  output logic resp_error,
  output logic [127:0] resp_data
);

  // last count of the power-up wait; never below one cycle
  localparam int unsigned PWR_WAIT = (POWERUP_CYCLES < 1) ? 1 : POWERUP_CYCLES;
  localparam logic [`CIR_PWR_CNT_W-1:0] PWR_LAST = `CIR_PWR_CNT_W'(PWR_WAIT - 1);

  // write-once field masks within csd bits 15:8
  localparam logic [7:0] W1_MASK [`CIR_W1_FIELDS] = '{
    `CIR_W1_FMT_GRP,
    `CIR_W1_COPY,
    `CIR_W1_PERM_WP,
    `CIR_W1_FMT
  };

  cir_pkg::cir_state_t cur;
  cir_pkg::cir_state_t nxt;

  logic ready;
  logic [31:0] ocr_image;
  logic [127:0] cid_image;
  logic [127:0] csd_image;
  logic [6:0] cid_crc;
  logic [6:0] csd_crc;
  logic [119:0] cid_body;
  logic [119:0] csd_body;
  logic [109:0] csd_fixed;
  logic [1:0] layout_version;
  logic [7:0] prog_req;
  logic [`CIR_W1_FIELDS-1:0] once_change;
  logic [`CIR_W1_FIELDS-1:0] once_blocked;
  logic ro_mismatch;
  logic prog_reject;

  assign ready = (cur.phase == cir_pkg::CIR_READY);

  // operating conditions, rebuilt every cycle from live state
  always_comb begin
    ocr_image = `CIR_OCR_RESET;
    ocr_image[`CIR_OCR_BUSY_N] = ready;
    // capacity reads zero while busy so a host cannot act on it early
    ocr_image[`CIR_OCR_CAPACITY] = ready & HIGH_CAPACITY;
    ocr_image[`CIR_OCR_DIFF_IF] = DIFF_IF_SUPPORT;
    ocr_image[`CIR_OCR_LOW_VOLT] = cur.low_volt_ok;
    ocr_image[`CIR_OCR_WIN_HI:`CIR_OCR_WIN_LO] = VOLT_WINDOW;
    ocr_image[`CIR_OCR_DUAL_VOLT] = cur.dual_volt;
  end

  // identification body: every field a build-time constant
  assign cid_body = {
    MAKER_CODE,
    APP_CODE,
    PRODUCT_NAME,
    REV_MAJOR,
    REV_MINOR,
    SERIAL_NUMBER,
    4'h0,
    MFG_YEAR,
    MFG_MONTH
  };

  cir_crc7 #(
    .DATA_W(`CIR_CRC_BODY_W)
  ) u_cid_crc (
    .data(cid_body),
    .crc(cid_crc)
  );

  // trailing bit of the register is always one
  assign cid_image = {cid_body, cid_crc, 1'b1};

  // structure version follows the capacity class
  assign layout_version = HIGH_CAPACITY ? `CIR_CSD_VER_2 : `CIR_CSD_VER_1;

  // reserved slots of the body are forced low whatever the parameter holds
  assign csd_fixed = CSD_BODY & `CIR_CSD_RO_MASK;

  // programmable byte masked so its reserved pair stays zero
  assign csd_body = {layout_version, csd_fixed, cur.csd_prog & `CIR_CSD_PROG_MASK};

  cir_crc7 #(
    .DATA_W(`CIR_CRC_BODY_W)
  ) u_csd_crc (
    .data(csd_body),
    .crc(csd_crc)
  );

  // crc is recomputed so it always matches the stored contents
  assign csd_image = {csd_body, csd_crc, 1'b1};

  // program request: compare against what the card already holds
  assign prog_req = prog_data[15:8];
  assign ro_mismatch = (prog_data[127:16] != csd_image[127:16]) |
                       (|(prog_req & ~`CIR_CSD_PROG_MASK));

  // one check per write-once field
  genvar gi;
  generate
    for (gi = 0; gi < `CIR_W1_FIELDS; gi++) begin : g_once
      assign once_change[gi] = |((prog_req ^ cur.csd_prog) & W1_MASK[gi]);
      assign once_blocked[gi] = once_change[gi] & cur.once_done[gi];
    end
  endgenerate

  // a rejected program leaves every cell as it was
  assign prog_reject = ro_mismatch | (|once_blocked);

  // next-state logic: power-up, command decode, responses
  always_comb begin
    nxt = cur;
    // responses last a single cycle
    nxt.resp_valid = 1'b0;
    nxt.resp_long = 1'b0;
    nxt.resp_error = 1'b0;

    // internal power-up sequence
    case (cur.phase)
      cir_pkg::CIR_POWERING: begin
        if (cur.pwr_cnt == PWR_LAST) begin
          nxt.phase = cir_pkg::CIR_READY;
        end else begin
          nxt.pwr_cnt = cur.pwr_cnt + `CIR_PWR_CNT_W'(1);
        end
      end
      cir_pkg::CIR_READY: begin
        nxt.pwr_cnt = cur.pwr_cnt;
      end
      default: begin
        nxt.phase = cir_pkg::CIR_POWERING;
      end
    endcase

    // the only path into the registers is a command
    if (cmd_valid) begin
      case (cmd_index)
        `CIR_CMD_GO_IDLE: begin
          // back to idle forgets the negotiated flags, not power-up
          nxt.dual_volt = 1'b0;
          nxt.low_volt_ok = 1'b0;
        end
        `CIR_CMD_IF_COND: begin
          nxt.dual_volt = DUAL_VOLTAGE;
          nxt.resp_valid = 1'b1;
          nxt.resp_data = {116'h0, cmd_arg[11:0]};
        end
        `CIR_CMD_OP_COND: begin
          // switch accepted only when asked for, supported and powered
          if (ready && LOW_VOLT_SUPPORT && cmd_arg[`CIR_OCR_LOW_VOLT]) begin
            nxt.low_volt_ok = 1'b1;
          end
          nxt.resp_valid = 1'b1;
          nxt.resp_data = {96'h0, ocr_image};
          if (ready && LOW_VOLT_SUPPORT && cmd_arg[`CIR_OCR_LOW_VOLT]) begin
            nxt.resp_data[`CIR_OCR_LOW_VOLT] = 1'b1;
          end
        end
        `CIR_CMD_ALL_SEND_ID,
        `CIR_CMD_SEND_ID: begin
          if (ready) begin
            nxt.resp_valid = 1'b1;
            nxt.resp_long = 1'b1;
            nxt.resp_data = cid_image;
          end
        end
        `CIR_CMD_SEND_CSD: begin
          if (ready) begin
            nxt.resp_valid = 1'b1;
            nxt.resp_long = 1'b1;
            nxt.resp_data = csd_image;
          end
        end
        `CIR_CMD_PROG_CSD: begin
          if (ready) begin
            nxt.resp_valid = 1'b1;
            nxt.resp_data = 128'h0;
            if (prog_reject) begin
              nxt.resp_error = 1'b1;
            end else begin
              nxt.csd_prog = prog_req & `CIR_CSD_PROG_MASK;
              nxt.once_done = cur.once_done | once_change;
            end
          end
        end
        default: begin
          // commands outside this set get no answer here
          nxt.resp_valid = 1'b0;
        end
      endcase
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cur.phase <= cir_pkg::CIR_POWERING;
      cur.pwr_cnt <= '0;
      cur.dual_volt <= 1'b0;
      cur.low_volt_ok <= 1'b0;
      cur.once_done <= '0;
      cur.csd_prog <= `CIR_CSD_PROG_RESET;
      cur.resp_valid <= 1'b0;
      cur.resp_long <= 1'b0;
      cur.resp_error <= 1'b0;
      cur.resp_data <= 128'h0;
    end else begin
      cur <= nxt;
    end
  end

  // outputs come straight from the state register
  assign resp_valid = cur.resp_valid;
  assign resp_long = cur.resp_long;
  assign resp_error = cur.resp_error;
  assign resp_data = cur.resp_data;

endmodule : cir_card_regs

//--- verif/cir_card_regs_monitor.sv
`timescale 1ns/1ps

module cir_card_regs_monitor #(
  parameter int unsigned POWERUP_CYCLES = 8
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_arg,
  input wire logic resp_valid,
  input wire logic resp_long,
  input wire logic resp_error,
  input wire logic [127:0] resp_data
);
  logic [31:0] up_cnt;

  // edges since reset release, saturating; margins of two absorb the ready-edge reading
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      up_cnt <= 32'h0;
    end else if (up_cnt != 32'hFFFF_FFFF) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // go-idle followed at once by a plain operating-conditions read (no switch request)
  sequence idle_then_read;
    cmd_valid && cmd_index == 6'h00 ##1 cmd_valid && cmd_index == 6'h29 && !cmd_arg[24];
  endsequence
  sequence ocr_answer;
    resp_valid && $past(cmd_index) == 6'h29;
  endsequence

  // answers only follow a taken command
  a_answer_has_cause: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  a_unknown_silent: assert property (cmd_valid && !(cmd_index inside {6'h00, 6'h02, 6'h08,
    6'h09, 6'h0A, 6'h1B, 6'h29}) |=> !resp_valid)
    else $error("unknown command answered");
  a_busy_bit_low: assert property (ocr_answer ##0 up_cnt < POWERUP_CYCLES - 2
    |-> !resp_data[31] && !resp_data[30])
    else $error("ready or capacity shown while busy");
  a_ready_bit_set: assert property (ocr_answer ##0 up_cnt > POWERUP_CYCLES + 2
    |-> resp_data[31])
    else $error("ready bit missing after power-up");
  a_capacity_gated: assert property (resp_valid && !resp_long && !resp_data[31]
    |-> !resp_data[30])
    else $error("capacity bit set while busy");
  a_ocr_reserved: assert property (ocr_answer |-> resp_data[127:32] == 96'h0
    && resp_data[28:25] == 4'h0 && resp_data[14:8] == 7'h0 && resp_data[6:0] == 7'h0)
    else $error("reserved operating bit not zero");
  a_cid_frame: assert property (resp_valid && $past(cmd_index) inside {6'h02, 6'h0A}
    |-> resp_long && resp_data[0] && resp_data[23:20] == 4'h0)
    else $error("identification frame wrong");
  a_csd_version: assert property (resp_valid && $past(cmd_index) == 6'h09
    |-> resp_long && !resp_data[127] && resp_data[0])
    else $error("layout version reserved value");
  a_idle_clears: assert property (idle_then_read |=> resp_valid && !resp_data[7]
    && !resp_data[24])
    else $error("flags not cleared by go-idle");
  a_error_source: assert property (resp_error |-> resp_valid
    && $past(cmd_index) == 6'h1B)
    else $error("error not from program command");
endmodule : cir_card_regs_monitor

bind cir_card_regs cir_card_regs_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES)) mon_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
  .cmd_arg(cmd_arg), .resp_valid(resp_valid), .resp_long(resp_long), .resp_error(resp_error),
  .resp_data(resp_data));

//--- verif/cir_host_model.sv
`timescale 1ns/1ps

module cir_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [5:0] cmd_index,
  output logic [31:0] cmd_arg,
  output logic [127:0] prog_data,
  input wire logic resp_valid,
  input wire logic resp_long,
  input wire logic resp_error,
  input wire logic [127:0] resp_data
);
  logic got;
  logic lng;
  logic err;
  logic [127:0] data;

  // quiet command lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_index = 6'h3F;
    cmd_arg = 32'h0;
    prog_data = 128'h0;
  end

  // registers are only reached by command; answer taken at the next edge
  task automatic send(input logic [5:0] i, input logic [31:0] a, input logic [127:0] p,
      input bit hold = 1'b0);
    cmd_valid = 1'b1;
    cmd_index = i;
    cmd_arg = a;
    prog_data = p;
    @(posedge sys_clk);
    #1;
    got = resp_valid;
    lng = resp_long;
    err = resp_error;
    data = resp_data;
    // released lines show inverted values, so stale data cannot pass;
    // one idle edge follows so a next call never rewrites a line in this step
    if (!hold) begin
      cmd_valid = 1'b0;
      cmd_index = ~i;
      cmd_arg = ~a;
      prog_data = ~p;
      @(posedge sys_clk);
      #1;
    end
  endtask : send
endmodule : cir_host_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb_top;
  // maker and application codes are arbitrary
  localparam logic [119:0] BODY = {8'hA5, 16'h4B4C, 40'h5445_5354_31, 8'h27, 32'hC0DE_0042,
    4'h0, 8'h11, 4'h4};
  localparam logic [39:0] PV = 40'h10_00_80_00_81;
  localparam logic [4:0] PE = 5'h03;
  // build options: window, capacity, dual voltage, low-voltage switch, differential
  localparam logic [12:0] CFG = {9'h1F0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic sys_clk, rst_b, cmd_valid, resp_valid, resp_long, resp_error;
  logic [5:0] cmd_index, idx;
  logic [31:0] cmd_arg, a;
  logic [127:0] prog_data, resp_data, img;
  int num_errors = 0;
  int compares = 0;

  cir_card_regs #(.MAKER_CODE(BODY[119:112]), .APP_CODE(BODY[111:96]),
    .PRODUCT_NAME(BODY[95:56]), .REV_MAJOR(BODY[55:52]), .REV_MINOR(BODY[51:48]),
    .SERIAL_NUMBER(BODY[47:16]), .MFG_YEAR(BODY[11:4]), .MFG_MONTH(BODY[3:0]),
    .VOLT_WINDOW(CFG[12:4]), .HIGH_CAPACITY(CFG[3]), .DUAL_VOLTAGE(CFG[2]),
    .LOW_VOLT_SUPPORT(CFG[1]), .DIFF_IF_SUPPORT(CFG[0]), .CSD_BODY({110{1'b1}}),
    .POWERUP_CYCLES(8)) cir_card_regs_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .prog_data(prog_data), .resp_valid(resp_valid), .resp_long(resp_long),
    .resp_error(resp_error), .resp_data(resp_data));

  cir_host_model host_inst (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .prog_data(prog_data), .resp_valid(resp_valid), .resp_long(resp_long),
    .resp_error(resp_error), .resp_data(resp_data));

  // expected operating-conditions image for this build
  function automatic logic [127:0] operating_conditions(input logic rdy, input logic dual, input logic lv);
    return {96'h0, rdy, rdy & CFG[3], CFG[0], 4'h0, lv & CFG[1], CFG[12:4], 7'h0,
      dual & CFG[2], 7'h0};
  endfunction : operating_conditions

  // checksum over the identification body, top bit first
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ 7'h09;
    end
    return c;
  endfunction : crc7

  task automatic close_out;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // watchdog well beyond the 131 cycles at most that the tests need
  initial begin
    #20000;
    num_errors++;
    close_out;
  end

  // main sequence
  initial begin
    a = $urandom(4628);
    rst_b = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    host_inst.send(6'h29, 32'h0, 128'h0);
    `CHK({host_inst.got, host_inst.data}, {1'b1, operating_conditions(1'b0, 1'b0, 1'b0)})
    host_inst.send(6'h0A, 32'h0, 128'h0);
    `CHK(host_inst.got, 1'b0)
    repeat (10) @(posedge sys_clk);
    #1 host_inst.send(6'h29, 32'h0100_0000, 128'h0);
    `CHK(host_inst.data, operating_conditions(1'b1, 1'b0, 1'b1))
    a = $urandom;
    host_inst.send(6'h08, a, 128'h0);
    `CHK(host_inst.data, {116'h0, a[11:0]})
    host_inst.send(6'h29, 32'h0, 128'h0);
    `CHK(host_inst.data, operating_conditions(1'b1, 1'b1, 1'b1))
    host_inst.send(6'h00, 32'h0, 128'h0, 1'b1);
    `CHK(host_inst.got, 1'b0)
    host_inst.send(6'h29, 32'h0, 128'h0);
    `CHK(host_inst.data, operating_conditions(1'b1, 1'b0, 1'b0))
    foreach (PE[i]) begin
      if (i < 2) begin
        host_inst.send(i ? 6'h0A : 6'h02, 32'h0, 128'h0, 1'b1);
        `CHK({host_inst.lng, host_inst.data}, {1'b1, BODY, crc7(BODY), 1'b1})
      end
    end
    host_inst.send(6'h09, 32'h0, 128'h0);
    img = host_inst.data;
    `CHK({img[127:120], img[75:74], img[30:29], img[20:16]}, 17'h08000)
    // write cell kinds: repeated, once-only lock, reserved pair
    for (int i = 0; i < 5; i++) begin
      img[15:8] = PV[39-8*i -: 8];
      host_inst.send(6'h1B, 32'h0, img);
      `CHK({host_inst.got, host_inst.err}, {1'b1, PE[4-i]})
    end
    host_inst.send(6'h09, 32'h0, 128'h0);
    `CHK(host_inst.data[15:8], 8'h80)
    repeat (40) begin
      idx = 6'($urandom);
      if (!(idx inside {6'h00, 6'h02, 6'h08, 6'h09, 6'h0A, 6'h1B, 6'h29})) begin
        host_inst.send(idx, $urandom, 128'h0);
        `CHK(host_inst.got, 1'b0)
      end
    end
    close_out;
  end
endmodule : tb_top
